// ===== hw/afp_defs.vh
/*
  Constants of the amplifier fault protection monitor: register offsets,
  status field layout, thresholds in code units and timing figures.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef AFP_DEFS_VH
`define AFP_DEFS_VH

// Clock rates in kHz
`define AFP_CORE_KHZ        100000
`define AFP_OP_KHZ          24576
`define AFP_ACC_W           17
`define AFP_ACC_STEP        17'h0_6000
`define AFP_ACC_WRAP        17'h1_86A0

// Times as printed
`define AFP_COOL_MS         200
`define AFP_STRAP_US        768
// Operating ticks at 24 576 per ms, strap time rounded up; sized so that
// the parameter defaults take them with no silent truncation
`define AFP_COOL_TICKS      23'h4B_0000
`define AFP_STRAP_TICKS     15'h49BB
`define AFP_COOL_W          23
`define AFP_STRAP_W         15

// Register offsets
`define AFP_REG_TEMP        8'h47
`define AFP_REG_VBATT       8'h48
`define AFP_REG_STATUS      8'h49
`define AFP_RD_W            16

// Code widths and thresholds: kelvin codes and 160 codes per volt
`define AFP_TEMP_W          9
`define AFP_VBATT_W         10
`define AFP_TEMP_TRIP       9'h1_B1
`define AFP_TEMP_RELEASE    9'h1_93
`define AFP_VBATT_TRIP      10'h1_70

// Fault channel indices and status layout
`define AFP_NCH             4
`define AFP_CH_OV           0
`define AFP_CH_OC           1
`define AFP_CH_UV           2
`define AFP_CH_OT           3
`define AFP_ST_ACT_LO       0
`define AFP_ST_EVT_LO       4
`define AFP_ST_STRAP_OK     8
`define AFP_ST_STRAP_VAL    9

`endif

// ===== hw/afp_fault_channel.v
/*
  One protection channel: a trip starts a cooling interval, at its end the
  hold condition is checked again and either the event ends or cools again.
  Assumes a one-cycle operating tick and synchronous trip and hold levels.
*/
`timescale 1ns/1ps
`include "afp_defs.vh"

module afp_fault_channel #(
  parameter [`AFP_COOL_W-1:0] COOL_TICKS = `AFP_COOL_TICKS
) (
  // Clock and reset
  input  wire i_core_clk,
  input  wire i_rst_n,
  input  wire i_clr,
  // Timing and fault levels
  input  wire i_tick,
  input  wire i_trip,
  input  wire i_hold,
  // Event state
  output reg  o_active,
  output reg  o_set_pulse
);

  localparam ST_IDLE = 1'b0;
  localparam ST_COOL = 1'b1;

  reg [`AFP_COOL_W-1:0] cnt_r;

  always @(posedge i_core_clk)
  begin
    if (!i_rst_n || i_clr)
    begin
      o_active    <= ST_IDLE;
      o_set_pulse <= 1'b0;
      cnt_r       <= {`AFP_COOL_W{1'b0}};
    end
    else
    begin
      o_set_pulse <= 1'b0;
      case (o_active)
        ST_IDLE:
        begin
          if (i_trip)
          begin
            o_active    <= ST_COOL;
            o_set_pulse <= 1'b1;
            cnt_r       <= COOL_TICKS;
          end
        end
        ST_COOL:
        begin
          if (i_tick)
          begin
            if (cnt_r == {{(`AFP_COOL_W-1){1'b0}}, 1'b1})
            begin
              // A fault still present restarts cooling, never a short retry
              if (i_hold)
                cnt_r <= COOL_TICKS;
              else
                o_active <= ST_IDLE;
            end
            else
              cnt_r <= cnt_r - {{(`AFP_COOL_W-1){1'b0}}, 1'b1};
          end
        end
        default: o_active <= ST_IDLE;
      endcase
    end
  end

endmodule // afp_fault_channel

// ===== hw/afp_monitor.v
/*
  Fault protection and monitoring controller of a boosted speaker amplifier:
  operating tick, four protection channels, strap capture, code registers,
  a register read port and an open-drain interrupt.
  Assumes all inputs synchronous to i_core_clk and analog codes held stable
  between conversions.
*/
`timescale 1ns/1ps
`include "afp_defs.vh"

module afp_monitor #(
  parameter [`AFP_COOL_W-1:0]  COOL_TICKS  = `AFP_COOL_TICKS,
  parameter [`AFP_STRAP_W-1:0] STRAP_TICKS = `AFP_STRAP_TICKS
) (
  // Clock and resets
  input  wire                    i_core_clk,
  input  wire                    i_rst_n,
  input  wire                    i_sw_reset,
  // Fault indications and sensor codes
  input  wire                    i_excess_voltage,
  input  wire                    i_excess_current,
  input  wire [`AFP_VBATT_W-1:0] i_vbatt_code,
  input  wire [`AFP_TEMP_W-1:0]  i_temp_code,
  // Strap pin
  input  wire                    i_second_addr_strap,
  // Register read port
  input  wire                    i_rd_en,
  input  wire [7:0]              i_rd_addr,
  output reg  [`AFP_RD_W-1:0]    o_rd_data,
  output reg                     o_rd_valid,
  // Protection state
  output reg                     o_excess_voltage_flag,
  output reg                     o_excess_current_flag,
  output reg                     o_low_battery_flag,
  output reg                     o_thermal_fault_flag,
  output reg                     o_analog_en,
  // Strap result
  output reg                     o_second_addr_strap,
  output reg                     o_strap_valid,
  // Open-drain interrupt
  output reg                     o_int_o,
  output reg                     o_int_oe
);

  function is_reg;
    input [7:0] addr;
    input [7:0] reg_off;
    begin
      is_reg = (addr == reg_off);
    end
  endfunction

  // Operating tick
  reg  [`AFP_ACC_W-1:0]   acc_r;
  reg                     tick_r;
  wire [`AFP_ACC_W-1:0]   acc_sum;
  // Sensor code registers
  reg  [`AFP_TEMP_W-1:0]  temp_code_r;
  reg  [`AFP_VBATT_W-1:0] vbatt_code_r;
  // Strap capture
  reg  [`AFP_STRAP_W-1:0] strap_cnt_r;
  reg                     strap_busy_r;
  // Channels
  wire [`AFP_NCH-1:0]     trip;
  wire [`AFP_NCH-1:0]     hold;
  wire [`AFP_NCH-1:0]     active;
  wire [`AFP_NCH-1:0]     set_pulse;
  reg  [`AFP_NCH-1:0]     evt_r;
  reg  [`AFP_NCH-1:0]     evt_nxt;
  wire                    st_rd;
  wire [`AFP_RD_W-1:0]    status;

  assign acc_sum = acc_r + `AFP_ACC_STEP;

  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      acc_r  <= {`AFP_ACC_W{1'b0}};
      tick_r <= 1'b0;
    end
    else if (acc_sum >= `AFP_ACC_WRAP)
    begin
      acc_r  <= acc_sum - `AFP_ACC_WRAP;
      tick_r <= 1'b1;
    end
    else
    begin
      acc_r  <= acc_sum;
      tick_r <= 1'b0;
    end
  end

  assign trip[`AFP_CH_OV] = i_excess_voltage;
  assign hold[`AFP_CH_OV] = i_excess_voltage;
  assign trip[`AFP_CH_OC] = i_excess_current;
  assign hold[`AFP_CH_OC] = i_excess_current;
  assign trip[`AFP_CH_UV] = (vbatt_code_r < `AFP_VBATT_TRIP);
  assign hold[`AFP_CH_UV] = (vbatt_code_r < `AFP_VBATT_TRIP);
  assign trip[`AFP_CH_OT] = (temp_code_r > `AFP_TEMP_TRIP);
  assign hold[`AFP_CH_OT] = (temp_code_r >= `AFP_TEMP_RELEASE);

  genvar g;
  generate
    for (g = 0; g < `AFP_NCH; g = g + 1)
    begin : g_ch
      afp_fault_channel #(
        .COOL_TICKS (COOL_TICKS)
      ) u_ch (
        .i_core_clk  (i_core_clk),
        .i_rst_n     (i_rst_n),
        .i_clr       (i_sw_reset),
        .i_tick      (tick_r),
        .i_trip      (trip[g]),
        .i_hold      (hold[g]),
        .o_active    (active[g]),
        .o_set_pulse (set_pulse[g])
      );
    end
  endgenerate

  always @(posedge i_core_clk)
  begin
    if (!i_rst_n || i_sw_reset)
    begin
      temp_code_r  <= {`AFP_TEMP_W{1'b0}};
      vbatt_code_r <= {`AFP_VBATT_W{1'b1}};
    end
    else
    begin
      temp_code_r  <= i_temp_code;
      vbatt_code_r <= i_vbatt_code;
    end
  end

  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      o_excess_voltage_flag <= 1'b0;
      o_excess_current_flag <= 1'b0;
      o_low_battery_flag    <= 1'b0;
      o_thermal_fault_flag  <= 1'b0;
      o_analog_en           <= 1'b0;
    end
    else
    begin
      o_excess_voltage_flag <= active[`AFP_CH_OV];
      o_excess_current_flag <= active[`AFP_CH_OC];
      o_low_battery_flag    <= active[`AFP_CH_UV];
      o_thermal_fault_flag  <= active[`AFP_CH_OT];
      o_analog_en           <= ~(|active) & ~i_sw_reset;
    end
  end

  // strap timer restarts on either reset
  always @(posedge i_core_clk)
  begin
    if (!i_rst_n || i_sw_reset)
    begin
      strap_cnt_r         <= STRAP_TICKS;
      strap_busy_r        <= 1'b1;
      o_strap_valid       <= 1'b0;
      o_second_addr_strap <= 1'b0;
    end
    else if (strap_busy_r && tick_r)
    begin
      if (strap_cnt_r == {{(`AFP_STRAP_W-1){1'b0}}, 1'b1})
      begin
        strap_busy_r        <= 1'b0;
        o_strap_valid       <= 1'b1;
        o_second_addr_strap <= i_second_addr_strap;
      end
      else
        strap_cnt_r <= strap_cnt_r - {{(`AFP_STRAP_W-1){1'b0}}, 1'b1};
    end
  end

  assign st_rd = i_rd_en && is_reg(i_rd_addr, `AFP_REG_STATUS);

  // Sticky events; a new set beats the clear-on-read
  always @*
  begin
    evt_nxt = evt_r;
    if (st_rd)
      evt_nxt = {`AFP_NCH{1'b0}};
    evt_nxt = evt_nxt | set_pulse;
  end

  always @(posedge i_core_clk)
  begin
    if (!i_rst_n || i_sw_reset)
    begin
      evt_r    <= {`AFP_NCH{1'b0}};
      o_int_oe <= 1'b0;
      o_int_o  <= 1'b0;
    end
    else
    begin
      evt_r    <= evt_nxt;
      o_int_oe <= |evt_nxt;
      o_int_o  <= 1'b0;
    end
  end

  assign status = {{(`AFP_RD_W-`AFP_ST_STRAP_VAL-1){1'b0}}, o_second_addr_strap,
                   o_strap_valid, evt_r, active};

  always @(posedge i_core_clk)
  begin
    if (!i_rst_n)
    begin
      o_rd_data  <= {`AFP_RD_W{1'b0}};
      o_rd_valid <= 1'b0;
    end
    else
    begin
      o_rd_valid <= i_rd_en;
      if (!i_rd_en)
        o_rd_data <= {`AFP_RD_W{1'b0}};
      else if (is_reg(i_rd_addr, `AFP_REG_TEMP))
        o_rd_data <= {{(`AFP_RD_W-`AFP_TEMP_W){1'b0}}, temp_code_r};
      else if (is_reg(i_rd_addr, `AFP_REG_VBATT))
        o_rd_data <= {{(`AFP_RD_W-`AFP_VBATT_W){1'b0}}, vbatt_code_r};
      else if (st_rd)
        o_rd_data <= status;
      else
        o_rd_data <= {`AFP_RD_W{1'b0}};
    end
  end

endmodule // afp_monitor

// ===== sim/afp_monitor_sva.sv
/* Checker of the protection monitor port behaviour.
   Assumes a bind to afp_monitor and a short COOL_TICKS. */
`timescale 1ns/1ps
module afp_monitor_sva #(
  parameter [22:0] COOL_TICKS = 23'd20
) (
  // Clock and resets
  input wire        i_core_clk,
  input wire        i_rst_n,
  input wire        i_sw_reset,
  // Fault causes and read port
  input wire        i_excess_voltage,
  input wire [9:0]  i_vbatt_code,
  input wire [8:0]  i_temp_code,
  input wire        i_rd_en,
  input wire [15:0] o_rd_data,
  input wire        o_rd_valid,
  // Protection state
  input wire        o_excess_voltage_flag,
  input wire        o_excess_current_flag,
  input wire        o_low_battery_flag,
  input wire        o_thermal_fault_flag,
  input wire        o_analog_en,
  input wire        o_int_oe
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n || i_sw_reset);
  reg [9:0] cnt_r;
  // Length of the current excess voltage event
  always @(posedge i_core_clk)
  begin
    cnt_r <= o_excess_voltage_flag ? cnt_r + 10'd1 : 10'd0;
  end
  AST_OV_SET: assert property (i_excess_voltage |-> ##2 o_excess_voltage_flag)
    else $error("excess voltage flag late");
  AST_OV_COOL: assert property ($fell(o_excess_voltage_flag) |-> cnt_r >= 4*COOL_TICKS-4)
    else $error("cooling interval short");
  AST_UV_SET: assert property (i_vbatt_code < 10'd368 |-> ##3 o_low_battery_flag)
    else $error("low battery flag late");
  AST_OT_SET: assert property (i_temp_code > 9'd433 |-> ##3 o_thermal_fault_flag)
    else $error("thermal flag late");
  AST_OT_END: assert property ($fell(o_thermal_fault_flag) |-> $past(i_temp_code, 3) < 9'd403)
    else $error("thermal event ended while hot");
  AST_ANALOG: assert property ($past(i_rst_n) && !$past(i_sw_reset) |-> o_analog_en ==
    !(o_excess_voltage_flag | o_excess_current_flag | o_low_battery_flag | o_thermal_fault_flag))
    else $error("analog enable disagrees with flags");
  AST_RD_ANS: assert property (i_rd_en |=> o_rd_valid)
    else $error("read not answered");
  AST_RD_IDLE: assert property (!i_rd_en |=> !o_rd_valid && o_rd_data == 16'h0000)
    else $error("read port busy while idle");
  AST_INT_SET: assert property ($rose(o_excess_voltage_flag) |-> o_int_oe)
    else $error("interrupt missing on new event");
endmodule // afp_monitor_sva

// ===== sim/afp_host.sv
/* Host model that issues register reads to the monitor.
   Assumes one read at a time, requested by a one-cycle pulse. */
`timescale 1ns/1ps
module afp_host (
  // Clock and request
  input  wire        i_core_clk,
  input  wire        i_req,
  input  wire [7:0]  i_addr,
  // Read port
  input  wire        i_rd_valid,
  input  wire [15:0] i_rd_data,
  output reg         o_rd_en = 1'b0,
  output reg  [7:0]  o_rd_addr = 8'h00,
  // Result
  output reg  [15:0] o_data = 16'h0000,
  output reg         o_done = 1'b0
);
  // Idle address toggles so nothing leans on a stale value
  always @(posedge i_core_clk)
  begin
    o_rd_en   <= i_req;
    o_rd_addr <= i_req ? i_addr : ~o_rd_addr;
    o_done    <= i_rd_valid;
    if (i_rd_valid)
      o_data <= i_rd_data;
  end
endmodule // afp_host

// ===== sim/afp_monitor_bench.sv
/* Self-checking bench of the protection monitor.
   Assumes short cooling and strap counts set at the instance. */
`timescale 1ns/1ps
module afp_monitor_bench;
  reg        i_core_clk, i_rst_n, i_sw_reset, i_excess_voltage, i_excess_current;
  reg        i_second_addr_strap, req;
  reg  [9:0] i_vbatt_code;
  reg  [8:0] i_temp_code;
  reg  [7:0] addr;
  reg [15:0] d;
  wire       i_rd_en, o_rd_valid, hdone, o_analog_en, o_second_addr_strap, o_strap_valid;
  wire       o_excess_voltage_flag, o_excess_current_flag, o_low_battery_flag;
  wire       o_thermal_fault_flag, o_int_o, o_int_oe;
  wire [7:0] i_rd_addr;
  wire [15:0] o_rd_data, hdata;
  wire [3:0] flg = {o_thermal_fault_flag, o_low_battery_flag, o_excess_current_flag,
                    o_excess_voltage_flag};
  integer    err_count, n_tests, i, ch;

  afp_monitor #(.COOL_TICKS(23'd20), .STRAP_TICKS(15'd10)) dut (.i_core_clk, .i_rst_n,
    .i_sw_reset, .i_excess_voltage, .i_excess_current, .i_vbatt_code, .i_temp_code,
    .i_second_addr_strap, .i_rd_en, .i_rd_addr, .o_rd_data, .o_rd_valid,
    .o_excess_voltage_flag, .o_excess_current_flag, .o_low_battery_flag,
    .o_thermal_fault_flag, .o_analog_en, .o_second_addr_strap, .o_strap_valid, .o_int_o,
    .o_int_oe);
  afp_host host (.i_core_clk, .i_req(req), .i_addr(addr), .i_rd_valid(o_rd_valid),
    .i_rd_data(o_rd_data), .o_rd_en(i_rd_en), .o_rd_addr(i_rd_addr), .o_data(hdata),
    .o_done(hdone));

  initial
  begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  task chk(input [15:0] g, input [15:0] e);
  begin
    n_tests = n_tests + 1;
    if (g !== e)
    begin
      err_count = err_count + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  end
  endtask

  task cyc(input integer n);
  begin
    repeat (n) @(posedge i_core_clk);
    #1;
  end
  endtask

  task rd(input [7:0] a);
  begin
    @(posedge i_core_clk);
    req  <= 1'b1;
    addr <= a;
    @(posedge i_core_clk);
    req <= 1'b0;
    for (i = 0; i < 8 && hdone !== 1'b1; i = i + 1)
      cyc(1);
    // An unanswered read counts, so stale data cannot pass a compare
    if (hdone !== 1'b1)
    begin
      err_count = err_count + 1;
      $display("mismatch t=%0t read done got=%h exp=%h", $time, hdone, 1'b1);
    end
    d = hdata;
  end
  endtask

  // Trip values sit one code past each threshold
  task fault(input integer c, input on);
  begin
    @(posedge i_core_clk);
    case (c)
      0: i_excess_voltage <= on;
      1: i_excess_current <= on;
      2: i_vbatt_code <= on ? 10'd367 : 10'd368;
      default: i_temp_code <= on ? 9'd434 : 9'd402;
    endcase
  end
  endtask

  task end_of_test;
  begin
    $display("tests %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  end
  endtask

  initial
  begin
    #200000;
    err_count = err_count + 1;
    end_of_test;
  end

  initial
  begin
    err_count = 0;
    n_tests = 0;
    {i_rst_n, i_sw_reset, i_excess_voltage, i_excess_current, req} = 5'b0_0000;
    i_second_addr_strap = 1'b1;
    i_vbatt_code = 10'd368;
    i_temp_code = 9'd433;
    addr = 8'h00;
    repeat (10) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    cyc(30);
    chk(o_strap_valid, 1'b0);
    chk(flg, 4'h0);
    cyc(25);
    chk({o_strap_valid, o_second_addr_strap}, 2'b11);
    rd(8'h47);
    chk(d, 16'h01B1);
    rd(8'h48);
    chk(d, 16'h0170);
    rd(8'h50);
    chk(d, 16'h0000);
    $display("test reset and reads done");
    for (ch = 0; ch < 4; ch = ch + 1)
    begin
      fault(ch, 1'b1);
      fault(ch, 1'b0);
      cyc(4);
      chk(flg[ch], 1'b1);
      chk({o_analog_en, o_int_oe, o_int_o}, 3'b010);
      cyc(66);
      chk(flg[ch], 1'b1);
      cyc(40);
      chk({flg[ch], o_analog_en}, 2'b01);
      rd(8'h49);
      chk(d, 16'h0300 | (16'h0010 << ch));
      cyc(2);
      chk(o_int_oe, 1'b0);
      fault(ch, 1'b1);
      cyc(200);
      chk(flg[ch], 1'b1);
      if (ch == 3)
      begin
        // The release level itself still holds the event
        @(posedge i_core_clk);
        i_temp_code <= 9'd403;
        cyc(200);
        chk(flg[ch], 1'b1);
      end
      fault(ch, 1'b0);
      cyc(110);
      chk({flg[ch], o_analog_en}, 2'b01);
      rd(8'h49);
      chk(d, 16'h0300 | (16'h0010 << ch));
      $display("test channel %0d done", ch);
    end
    fault(0, 1'b1);
    fault(0, 1'b0);
    cyc(40);
    fault(1, 1'b1);
    fault(1, 1'b0);
    cyc(70);
    chk({flg, o_analog_en}, 5'b0010_0);
    cyc(40);
    chk({flg, o_analog_en}, 5'b0000_1);
    rd(8'h49);
    chk(d, 16'h0330);
    $display("test overlap done");
    // software reset restarts the strap timer
    @(posedge i_core_clk);
    i_second_addr_strap <= 1'b0;
    i_sw_reset <= 1'b1;
    @(posedge i_core_clk);
    i_sw_reset <= 1'b0;
    cyc(30);
    chk(o_strap_valid, 1'b0);
    cyc(25);
    rd(8'h49);
    chk(d, 16'h0100);
    $display("test soft reset done");
    end_of_test;
  end
endmodule // afp_monitor_bench

bind afp_monitor afp_monitor_sva #(.COOL_TICKS(COOL_TICKS)) u_sva (.i_core_clk, .i_rst_n,
  .i_sw_reset, .i_excess_voltage, .i_vbatt_code, .i_temp_code, .i_rd_en, .o_rd_data,
  .o_rd_valid, .o_excess_voltage_flag, .o_excess_current_flag, .o_low_battery_flag,
  .o_thermal_fault_flag, .o_analog_en, .o_int_oe);
